/* verilog/dic_pkg.sv */
// Constants and register map shared by the dual level interrupt controller.
package dic_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned DW       = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned PERIPH_W = 21;
  localparam int unsigned EV_W     = 3;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_NORMAL_RAW_STATUS    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_ENABLE_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_MASK_CLEAR    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_MASKED_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FAST_RAW_STATUS      = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FAST_ENABLE_MASK     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FAST_MASK_CLEAR      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FAST_MASKED_STATUS   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_SOFTWARE_INT_CONFIG  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS         = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK           = 8'h28;

  // ==========================================================================
  // Source bit positions, common to every status and mask register except the event ones
  // ==========================================================================
  localparam int unsigned FAST_POS  = 0;
  localparam int unsigned SWI_POS   = 1;
  localparam int unsigned SRC_LO    = 2;
  localparam int unsigned SRC_HI    = 24;
  localparam int unsigned EXT_A_POS = 15;
  localparam int unsigned EXT_B_POS = 18;

  // Positions 2..24 are real sources; position 1 is never maskable.
  localparam logic [DW-1:0] SRC_MASK = 32'h01ff_fffc;

  // ==========================================================================
  // Software interrupt configuration fields
  // ==========================================================================
  localparam int unsigned SWI_CFG_NORMAL_BIT = 1;
  localparam int unsigned SWI_CFG_FAST_BIT   = 2;

  // ==========================================================================
  // Controller event bits (event status and event mask registers)
  // ==========================================================================
  localparam int unsigned EV_NORMAL_RISE = 0;
  localparam int unsigned EV_FAST_RISE   = 1;
  localparam int unsigned EV_EN_CONFLICT = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DW-1:0]   EN_RESET   = 32'h0000_0000;
  localparam logic [DW-1:0]   WORD_ZERO  = 32'h0000_0000;
  localparam logic [1:0]      SWI_RESET  = 2'h0;
  localparam logic [EV_W-1:0] EV_RESET   = 3'h0;
  localparam logic [1:0]      SYNC_RESET = 2'h0;

endpackage

/* verilog/dic_src_if.sv */
// Source status vector passed from the source conditioner to the controller.
`timescale 1ns/1ns
interface dic_src_if;
  import dic_pkg::*;

  logic [DW-1:0] raw;

  modport drv  (output raw);
  modport sink (input  raw);
endinterface

/* verilog/dic_src_cond.sv */
// Source conditioner: synchronises the external request pins and places sources.
`timescale 1ns/1ns
module dic_src_cond
  import dic_pkg::*;
#(
  parameter int unsigned N_PERIPH = PERIPH_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [N_PERIPH-1:0] periph_req,
  input  wire logic                ext_pin_a,
  input  wire logic                ext_pin_b,
  dic_src_if.drv                   src
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } dic_sync_s;

  dic_sync_s st_r;
  dic_sync_s st_nxt;

  // Pins are asynchronous to clk; only the second stage is ever looked at.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = {ext_pin_b, ext_pin_a};
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{s1: SYNC_RESET, s2: SYNC_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Placement of the sources onto their fixed bit positions
  // ==========================================================================
  always_comb begin
    int k;
    k       = 0;
    src.raw = WORD_ZERO;
    for (int p = SRC_LO; p <= SRC_HI; p++) begin // [R02]
      if (p == EXT_A_POS) begin
        src.raw[p] = st_r.s2[0];
      end else if (p == EXT_B_POS) begin
        src.raw[p] = st_r.s2[1];
      end else if (k < N_PERIPH) begin
        src.raw[p] = periph_req[k];
        k          = k + 1;
      end
    end
  end

endmodule

/* verilog/dic_ctrl.sv */
// Dual level interrupt controller with APB register access.
//
// Functional notes
// R01 - Take 21 peripheral sources and two pins; drive normal and fast requests.
// R02 - All status, enable, clear and masked registers share one bit layout.
// R03 - Normal enable bit one lets its source request; zero masks it.
// R04 - Raw status follows the source level and is read-only.
// R05 - Writing ones to normal mask-clear clears those enable bits only.
// R06 - Normal masked status is raw status ANDed with normal enable.
// R07 - Normal request is the OR of all normal masked-status bits.
// R08 - No priority encoding or vector; software reads masked status.
// R09 - Fast level has its own raw, enable, clear and masked registers.
// R10 - Fast request ORs fast masked bits 31..1; bit 0 shows it.
// R11 - Setting a fast enable bit clears the same normal enable bit.
// R12 - Setting a normal enable bit clears the same fast enable bit.
// R13 - Programmed interrupts bypass the masks via the software config register.
// R14 - Software config bit 1 drives bit 1 of normal raw and masked.
// R15 - Software config bit 2 drives bit 1 of fast raw and masked.
// R16 - Bit 1 is inert in enable and mask-clear registers of both levels.
// R17 - Sources hold their request long enough to be seen.
// R18 - Requests are levels; enable masks reset to zero.
// R19 - Reserved and unused source bits read zero and ignore writes.
`timescale 1ns/1ns
module dic_ctrl
  import dic_pkg::*;
#(
  parameter int unsigned N_PERIPH = PERIPH_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DW-1:0]       pwdata,
  output      logic [DW-1:0]       prdata,
  output      logic                pready,
  output      logic                pslverr,
  input  wire logic [N_PERIPH-1:0] periph_req,
  input  wire logic                ext_pin_a,
  input  wire logic                ext_pin_b,
  output      logic                normal_req,
  output      logic                fast_req,
  output      logic                evt_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [DW-1:0]   src;
    logic [DW-1:0]   nen;
    logic [DW-1:0]   fen;
    logic [1:0]      software_interrupt_source;
    logic            nreq;
    logic            freq;
    logic [EV_W-1:0] evs;
    logic [EV_W-1:0] evm;
    logic [DW-1:0]   rdata;
    logic            err;
  } dic_state_s;

  dic_state_s st_r;
  dic_state_s st_nxt;

  // ==========================================================================
  // Source conditioning
  // ==========================================================================
  dic_src_if src_if ();

  dic_src_cond #(
    .N_PERIPH (N_PERIPH)
  ) u_src (
    .clk        (clk),
    .rst_n      (rst_n),
    .periph_req (periph_req),
    .ext_pin_a  (ext_pin_a),
    .ext_pin_b  (ext_pin_b),
    .src        (src_if.drv)
  );

  // ==========================================================================
  // Views shared by both levels
  // ==========================================================================
  // Raw view: live sources, the programmed bit and the fast request bit.
  function automatic logic [DW-1:0] raw_view(
    input logic [DW-1:0] src,
    input logic          software_interrupt_source,
    input logic          fq
  );
    logic [DW-1:0] v;
    v           = src & SRC_MASK;              // [R19]
    v[SWI_POS]  = software_interrupt_source;                          // [R13]
    v[FAST_POS] = fq;                           // [R10]
    return v;
  endfunction

  // Masked view: raw sources gated by the enable mask; bit 1 is never gated.
  function automatic logic [DW-1:0] masked_view(
    input logic [DW-1:0] src,
    input logic [DW-1:0] en,
    input logic          software_interrupt_source,
    input logic          fq
  );
    logic [DW-1:0] v;
    v           = src & en & SRC_MASK;         // [R03] [R06]
    v[SWI_POS]  = software_interrupt_source;                          // [R13]
    v[FAST_POS] = fq;                           // [R10]
    return v;
  endfunction

  // Enable mask update: set, clear and the cross-level side effect in one place.
  function automatic logic [DW-1:0] en_update(
    input logic [DW-1:0] cur,
    input logic [DW-1:0] set_own,
    input logic [DW-1:0] clr_own,
    input logic [DW-1:0] set_other
  );
    return ((cur | set_own) & ~clr_own & ~set_other) & SRC_MASK; // [R11] [R12]
  endfunction

  // ==========================================================================
  // Bus phase decode
  // ==========================================================================
  logic          setup_ph;
  logic          wr_acc;
  logic          rd_acc;
  logic [DW-1:0] wr_val;
  logic [DW-1:0] set_n;
  logic [DW-1:0] clr_n;
  logic [DW-1:0] set_f;
  logic [DW-1:0] clr_f;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;

  // Bit 1 and every bit outside the source range are dropped before use.
  assign wr_val = pwdata & SRC_MASK;            // [R16] [R19]

  assign set_n = (wr_acc && paddr == OFS_NORMAL_ENABLE_MASK) ? wr_val : WORD_ZERO;
  assign clr_n = (wr_acc && paddr == OFS_NORMAL_MASK_CLEAR)  ? wr_val : WORD_ZERO; // [R05]
  assign set_f = (wr_acc && paddr == OFS_FAST_ENABLE_MASK)   ? wr_val : WORD_ZERO;
  assign clr_f = (wr_acc && paddr == OFS_FAST_MASK_CLEAR)    ? wr_val : WORD_ZERO; // [R09]

  // ==========================================================================
  // Current register views
  // ==========================================================================
  logic [DW-1:0] n_raw;
  logic [DW-1:0] n_msk;
  logic [DW-1:0] f_raw;
  logic [DW-1:0] f_msk;
  logic [DW-1:0] swi_word;
  logic [DW-1:0] evs_word;
  logic [DW-1:0] evm_word;

  assign n_raw = raw_view(st_r.src, st_r.software_interrupt_source[0], st_r.freq);              // [R04] [R14]
  assign f_raw = raw_view(st_r.src, st_r.software_interrupt_source[1], st_r.freq);              // [R09] [R15]
  assign n_msk = masked_view(st_r.src, st_r.nen, st_r.software_interrupt_source[0], st_r.freq); // [R14]
  assign f_msk = masked_view(st_r.src, st_r.fen, st_r.software_interrupt_source[1], st_r.freq); // [R15]

  always_comb begin
    swi_word                     = WORD_ZERO;
    swi_word[SWI_CFG_NORMAL_BIT] = st_r.software_interrupt_source[0];
    swi_word[SWI_CFG_FAST_BIT]   = st_r.software_interrupt_source[1];
    evs_word                     = WORD_ZERO;
    evs_word[EV_W-1:0]           = st_r.evs;
    evm_word                     = WORD_ZERO;
    evm_word[EV_W-1:0]           = st_r.evm;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic            nreq_c;
  logic            freq_c;
  logic            conflict;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_clr;
  logic [DW-1:0]   n_msk_next;

  always_comb begin
    st_nxt = st_r;

    // Sources are sampled every cycle; raw status follows them.
    st_nxt.src = src_if.raw & SRC_MASK;                             // [R01] [R04]

    // Enable masks.
    st_nxt.nen = en_update(st_r.nen, set_n, clr_n, set_f);          // [R05] [R11]
    st_nxt.fen = en_update(st_r.fen, set_f, clr_f, set_n);          // [R12]

    // Programmed interrupts are written directly, never through a mask.
    if (wr_acc && paddr == OFS_SOFTWARE_INT_CONFIG) begin
      st_nxt.software_interrupt_source[0] = pwdata[SWI_CFG_NORMAL_BIT];                   // [R14]
      st_nxt.software_interrupt_source[1] = pwdata[SWI_CFG_FAST_BIT];                     // [R15]
    end

    // Fast request: bits 31..1 of the fast masked view only.
    freq_c = |f_msk[DW-1:SWI_POS];                                  // [R10]

    // Normal request: all 32 masked bits, bit 0 carrying the fast request.
    n_msk_next           = n_msk;
    n_msk_next[FAST_POS] = freq_c;
    nreq_c               = |n_msk_next;                             // [R07] [R18]

    st_nxt.nreq = nreq_c;                                           // [R18]
    st_nxt.freq = freq_c;

    // Controller events.
    conflict                = |(set_n & st_r.fen) | |(set_f & st_r.nen);
    ev                      = EV_RESET;
    ev[EV_NORMAL_RISE]      = nreq_c & ~st_r.nreq;
    ev[EV_FAST_RISE]        = freq_c & ~st_r.freq;
    ev[EV_EN_CONFLICT]      = conflict;

    // A read clears only what it returned, and a new event wins over it.
    ev_clr = EV_RESET;
    if (rd_acc && paddr == OFS_EVENT_STATUS) begin
      ev_clr = st_r.rdata[EV_W-1:0];
    end
    st_nxt.evs = (st_r.evs & ~ev_clr) | ev;

    if (wr_acc && paddr == OFS_EVENT_MASK) begin
      st_nxt.evm = pwdata[EV_W-1:0];
    end

    // Read data and error are prepared in the setup phase so that the access
    // phase can complete with no wait state.
    if (setup_ph) begin
      st_nxt.err = 1'b0;
      unique case (paddr)
        OFS_NORMAL_RAW_STATUS:    st_nxt.rdata = n_raw;            // [R04]
        OFS_NORMAL_ENABLE_MASK:   st_nxt.rdata = st_r.nen;
        OFS_NORMAL_MASK_CLEAR:    st_nxt.rdata = WORD_ZERO;
        OFS_NORMAL_MASKED_STATUS: st_nxt.rdata = n_msk_next;       // [R08]
        OFS_FAST_RAW_STATUS:      st_nxt.rdata = f_raw;
        OFS_FAST_ENABLE_MASK:     st_nxt.rdata = st_r.fen;
        OFS_FAST_MASK_CLEAR:      st_nxt.rdata = WORD_ZERO;
        OFS_FAST_MASKED_STATUS:   st_nxt.rdata = f_msk;            // [R08]
        OFS_SOFTWARE_INT_CONFIG:  st_nxt.rdata = swi_word;
        OFS_EVENT_STATUS:         st_nxt.rdata = evs_word;
        OFS_EVENT_MASK:           st_nxt.rdata = evm_word;
        default: begin
          st_nxt.rdata = WORD_ZERO;
          st_nxt.err   = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.src   <= WORD_ZERO;
      st_r.nen   <= EN_RESET;                                       // [R18]
      st_r.fen   <= EN_RESET;                                       // [R18]
      st_r.software_interrupt_source   <= SWI_RESET;
      st_r.nreq  <= 1'b0;
      st_r.freq  <= 1'b0;
      st_r.evs   <= EV_RESET;
      st_r.evm   <= EV_RESET;
      st_r.rdata <= WORD_ZERO;
      st_r.err   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The slave never inserts wait states.
  assign pready  = 1'b1;
  assign prdata  = st_r.rdata;
  assign pslverr = psel & penable & st_r.err;

  assign normal_req = st_r.nreq;                                    // [R07]
  assign fast_req   = st_r.freq;                                    // [R10]
  assign evt_irq    = |(st_r.evs & st_r.evm);

  // Sources that pulse high only between two clock edges are never sampled and are lost; the
  // peripherals are expected to hold their lines until serviced.
  // Path: pin to request is four edges, peripheral line to request two. [R17]

endmodule

/* sim/dic_core_model.sv */
// Behavioural processor core that counts each new request offered on either line.
`timescale 1ns/1ns
module dic_core_model
  import dic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       normal_req,
  input  wire logic       fast_req,
  output      logic [7:0] fast_takes,
  output      logic [7:0] normal_takes
);
  typedef struct packed {
    logic       seen;
    logic [7:0] cnt;
    logic       nseen;
    logic [7:0] ncnt;
  } dic_core_s;
  dic_core_s state_r;
  dic_core_s state_nxt;
  // A level held high is one request, so only a new level counts as an entry.
  always_comb begin
    state_nxt = state_r;
    state_nxt.seen = fast_req;
    if (fast_req && !state_r.seen) begin
      state_nxt.cnt = state_r.cnt + 8'h01;
    end
    state_nxt.nseen = normal_req;
    if (normal_req && !state_r.nseen) begin
      state_nxt.ncnt = state_r.ncnt + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign fast_takes   = state_r.cnt;
  assign normal_takes = state_r.ncnt;
endmodule

/* sim/dic_ctrl_properties.sv */
// Port-level assertions for the dual level interrupt controller.
`timescale 1ns/1ns
module dic_ctrl_props
  import dic_pkg::*;
#(
  parameter int unsigned N_PERIPH = PERIPH_W
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [DW-1:0]       prdata,
  input wire logic                pslverr,
  input wire logic [N_PERIPH-1:0] periph_req,
  input wire logic                ext_pin_a,
  input wire logic                ext_pin_b,
  input wire logic                normal_req,
  input wire logic                fast_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Helpers
  // ====================
  // Sampled functions cannot feed an always_comb, so this counter stays a plain flop.
  logic [3:0] quiet_r;
  logic       far_addr;
  assign far_addr = (paddr > OFS_EVENT_MASK);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= 4'h0;
    end else if ($changed(periph_req) || $changed({ext_pin_a, ext_pin_b})
                 || (psel && penable && pwrite)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  sequence rd_s;
    psel && penable && !pwrite;
  endsequence
  // ====================
  // Properties
  // ====================
  reset_idle_a: assert property ($rose(rst_n) |-> !normal_req && !fast_req)
    else $error("request high right after reset");
  fast_in_normal_a: assert property (fast_req |-> normal_req)
    else $error("fast request without normal request");
  req_level_a: assert property (quiet_r >= 4'h6 |-> $stable(normal_req) && $stable(fast_req))
    else $error("request moved with no cause");
  far_addr_err_a: assert property (rd_s ##0 far_addr |-> pslverr && prdata == WORD_ZERO)
    else $error("unmapped read not refused");
  err_access_a: assert property (pslverr |-> psel && penable && (far_addr || paddr[1:0] != 2'h0))
    else $error("error outside an unmapped access");
  clear_reads_zero_a: assert property (rd_s ##0
    (paddr == OFS_NORMAL_MASK_CLEAR || paddr == OFS_FAST_MASK_CLEAR) |-> prdata == WORD_ZERO)
    else $error("mask clear register read nonzero");
  unused_bits_a: assert property (rd_s ##0 (paddr <= OFS_FAST_MASKED_STATUS) |-> prdata[31:25] == 7'h00)
    else $error("unused source bits read nonzero");
  enable_bits_a: assert property (rd_s ##0
    (paddr == OFS_NORMAL_ENABLE_MASK || paddr == OFS_FAST_ENABLE_MASK) |-> prdata[1:0] == 2'h0)
    else $error("enable bit one or zero reads set");
  swi_cfg_bits_a: assert property (rd_s ##0 (paddr == OFS_SOFTWARE_INT_CONFIG)
    |-> prdata[31:3] == 29'h0 && !prdata[0])
    else $error("reserved config bits read set");
endmodule
bind dic_ctrl dic_ctrl_props #(.N_PERIPH(N_PERIPH)) u_dic_ctrl_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .periph_req(periph_req),
  .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b), .normal_req(normal_req),
  .fast_req(fast_req)
);

/* sim/tb_dual_level_interrupt_controller.sv */
// Self-checking bench: register access, source routing, masking and events.
`timescale 1ns/1ns
module tb_dual_level_interrupt_controller
  import dic_pkg::*;
;
  logic                clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic                ext_pin_a, ext_pin_b, normal_req, fast_req, evt_irq;
  logic [ADDR_W-1:0]   paddr;
  logic [DW-1:0]       pwdata, prdata, rd;
  logic [PERIPH_W-1:0] periph_req;
  logic [7:0]          fast_takes, normal_takes, takes0;
  int                  num_errors = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  dic_ctrl u_dic_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b),
    .normal_req(normal_req), .fast_req(fast_req), .evt_irq(evt_irq)
  );
  dic_core_model u_dic_core_model (
    .clk(clk), .rst_n(rst_n), .normal_req(normal_req), .fast_req(fast_req),
    .fast_takes(fast_takes), .normal_takes(normal_takes)
  );
  // ====================
  // Tasks
  // ====================
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // An idle cycle closes each transfer so no strobe is assigned twice in one step.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DW-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DW-1:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  task automatic reqs(input logic [1:0] want);
    chk({30'h0, normal_req, fast_req}, {30'h0, want});
  endtask
  // Pins pass two synchroniser flops, so four cycles cover every source path.
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  function automatic int src_pos(input int j);
    if (j > 20) return (j == 21) ? 15 : 18;
    return (j < 13) ? j + 2 : (j < 15) ? j + 3 : j + 4;
  endfunction
  // ====================
  // Clock, timeout and tests
  // ====================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {periph_req, ext_pin_a, ext_pin_b, rst_n} <= '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 40; a += 4) begin
      rchk(8'(a), 32'h0);
    end
    apb(1'b0, 8'h2c, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int j = 0; j < 23; j++) begin
      periph_req <= (j < 21) ? 21'h1 << j : 21'h0;
      ext_pin_a <= (j == 21);
      ext_pin_b <= (j == 22);
      settle();
      rchk(OFS_NORMAL_RAW_STATUS, 32'h1 << src_pos(j));
      rchk(OFS_FAST_RAW_STATUS, 32'h1 << src_pos(j));
      rchk(OFS_NORMAL_MASKED_STATUS, 32'h0);
      reqs(2'b00);
    end
    {ext_pin_a, ext_pin_b} <= 2'b00;
    periph_req <= '1;
    apb(1'b1, OFS_NORMAL_ENABLE_MASK, 32'hffff_ffff);
    settle();
    rchk(OFS_NORMAL_ENABLE_MASK, 32'h01ff_fffc);
    rchk(OFS_NORMAL_MASKED_STATUS, 32'h01fb_7ffc);
    reqs(2'b10);
    apb(1'b1, OFS_NORMAL_MASK_CLEAR, 32'h0000_4006);
    settle();
    rchk(OFS_NORMAL_MASK_CLEAR, 32'h0);
    rchk(OFS_NORMAL_MASKED_STATUS, 32'h01fb_3ff8);
    takes0 = fast_takes;
    apb(1'b1, OFS_FAST_ENABLE_MASK, 32'h0000_000a);
    settle();
    rchk(OFS_FAST_ENABLE_MASK, 32'h0000_0008);
    rchk(OFS_NORMAL_MASKED_STATUS, 32'h01fb_3ff1);
    rchk(OFS_FAST_MASKED_STATUS, 32'h0000_0009);
    reqs(2'b11);
    chk({24'h0, fast_takes - takes0}, 32'h1);
    apb(1'b1, OFS_NORMAL_ENABLE_MASK, 32'h0000_0008);
    apb(1'b1, OFS_FAST_ENABLE_MASK, 32'h0000_0030);
    apb(1'b1, OFS_FAST_MASK_CLEAR, 32'h0000_0010);
    settle();
    rchk(OFS_FAST_ENABLE_MASK, 32'h0000_0020);
    apb(1'b1, OFS_NORMAL_MASK_CLEAR, 32'hffff_ffff);
    apb(1'b1, OFS_FAST_MASK_CLEAR, 32'hffff_ffff);
    settle();
    rchk(OFS_NORMAL_ENABLE_MASK, 32'h0);
    reqs(2'b00);
    periph_req <= '0;
    takes0 = normal_takes;
    apb(1'b1, OFS_SOFTWARE_INT_CONFIG, 32'hffff_fff2);
    settle();
    rchk(OFS_SOFTWARE_INT_CONFIG, 32'h2);
    rchk(OFS_NORMAL_MASKED_STATUS, 32'h2);
    rchk(OFS_FAST_RAW_STATUS, 32'h0);
    reqs(2'b10);
    chk({24'h0, normal_takes - takes0}, 32'h1);
    apb(1'b1, OFS_SOFTWARE_INT_CONFIG, 32'h4);
    settle();
    rchk(OFS_FAST_MASKED_STATUS, 32'h3);
    rchk(OFS_NORMAL_RAW_STATUS, 32'h1);
    reqs(2'b11);
    apb(1'b1, OFS_SOFTWARE_INT_CONFIG, 32'h0);
    settle();
    reqs(2'b00);
    apb(1'b0, OFS_EVENT_STATUS, 32'h0);
    apb(1'b1, OFS_EVENT_MASK, 32'h7);
    apb(1'b1, OFS_SOFTWARE_INT_CONFIG, 32'h2);
    settle();
    chk({31'h0, evt_irq}, 32'h1);
    apb(1'b1, OFS_EVENT_MASK, 32'h6);
    chk({31'h0, evt_irq}, 32'h0);
    apb(1'b1, OFS_NORMAL_ENABLE_MASK, 32'h20);
    apb(1'b1, OFS_FAST_ENABLE_MASK, 32'h20);
    settle();
    chk({31'h0, evt_irq}, 32'h1);
    rchk(OFS_EVENT_STATUS, 32'h5);
    chk({31'h0, evt_irq}, 32'h0);
    rchk(OFS_EVENT_STATUS, 32'h0);
    end_sim();
  end
endmodule
